// ==== common/bma_consts.svh ====
// constants for the beacon monitor alarm controller
`ifndef BMA_CONSTS_SVH
`define BMA_CONSTS_SVH

`define BMA_NPARAM 7
`define BMA_MEAS_W 16
// parameter slots
`define BMA_P_REPLY_DELAY 3'h0
`define BMA_P_PULSE_SPACING 3'h1
`define BMA_P_PULSE_POWER 3'h2
`define BMA_P_TX_FREQ 3'h3
`define BMA_P_TX_RATE 3'h4
`define BMA_P_REPLY_EFF 3'h5
`define BMA_P_IDENT 3'h6
// fixed primary classes, promotable secondary classes
`define BMA_PRIMARY_MASK 7'h0F
`define BMA_PROMOTE_LSB 4
// reaction delays in seconds, 4 bits per slot, slot 0 lowest
`define BMA_DLY_DEFAULT 28'h1AA4444
`define BMA_DLY_MIN 4'h1
`define BMA_DLY_MAX 4'hA
// timing
`define BMA_CLK_HZ 125000000
`define BMA_TICK_S 1
`define BMA_TICK_CYCLES (`BMA_TICK_S * `BMA_CLK_HZ)
`define BMA_INHIBIT_S 5
`define BMA_INHIBIT_TICKS 3'h5
`define BMA_ID_MISS_LIMIT 2'h2

`endif

// ==== common/bma_pkg.sv ====
// types for the beacon monitor alarm controller
package bma_pkg;

    typedef enum logic [1:0] {
        BMA_INHIBIT = 2'h0,
        BMA_RUN = 2'h1,
        BMA_OFF = 2'h3
    } bma_state_e;

    typedef logic [6:0] bma_param_t;

endpackage : bma_pkg

// ==== verilog/bma_alarm_ctrl.sv ====
// executive monitoring alarm controller
`timescale 1ns/10ps
`include "bma_consts.svh"

module bma_alarm_ctrl #(
    parameter int unsigned TICK_CYCLES = `BMA_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // equipment power-on command
    input wire logic pwr_on,
    // configuration
    input wire logic cfg_wr,
    input wire logic cfg_or_policy,
    input wire logic cfg_dual,
    input wire logic cfg_hot,
    input wire logic [2:0] cfg_promote,
    input wire logic cfg_dly_wr,
    input wire logic [2:0] cfg_dly_idx,
    input wire logic [3:0] cfg_dly_val,
    // monitor A
    input wire logic mon_a_ok,
    input wire logic [5:0] mon_a_oot,
    input wire logic [5:0] mon_a_sb_oot,
    input wire logic mon_a_id_cycle,
    input wire logic mon_a_id_ok,
    input wire logic mon_a_meas_wr,
    input wire logic [2:0] mon_a_meas_idx,
    input wire logic [15:0] mon_a_meas_val,
    // monitor B
    input wire logic mon_b_ok,
    input wire logic [5:0] mon_b_oot,
    input wire logic [5:0] mon_b_sb_oot,
    input wire logic mon_b_id_cycle,
    input wire logic mon_b_id_ok,
    input wire logic mon_b_meas_wr,
    input wire logic [2:0] mon_b_meas_idx,
    input wire logic [15:0] mon_b_meas_val,
    // operator interface
    input wire logic [2:0] op_idx,
    output logic [15:0] op_val_a,
    output logic [15:0] op_val_b,
    input wire logic alarm_ack,
    // transponder control
    output logic tx_enable,
    output logic active_sel,
    output logic standby_tx_on,
    // status and alarms
    output logic policy_or,
    output logic eval_live,
    output logic alarm_primary,
    output logic alarm_secondary,
    output logic alarm_visual,
    output logic alarm_acoustic,
    output logic alarm_remote,
    output logic [2:0] cause_param,
    output logic [15:0] cause_value,
    output logic cause_mon_b
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic bma_pkg::bma_param_t fn_combine(
        input logic use_or,
        input logic ok_a,
        input logic ok_b,
        input bma_pkg::bma_param_t a,
        input bma_pkg::bma_param_t b
    );
        bma_pkg::bma_param_t r;
        if (use_or)
            r = a | b;
        else if (ok_a && ok_b)
            r = a & b;
        else if (ok_a)
            r = a;
        else if (ok_b)
            r = b;
        else
            r = 7'h00;
        return r;
    endfunction : fn_combine

    function automatic logic [1:0] fn_miss(
        input logic [1:0] miss,
        input logic seen
    );
        logic [1:0] r;
        if (seen)
            r = 2'h0;
        else if (miss == `BMA_ID_MISS_LIMIT)
            r = miss;
        else
            r = miss + 2'h1;
        return r;
    endfunction : fn_miss

    function automatic logic [3:0] fn_clamp(input logic [3:0] v);
        logic [3:0] r;
        if (v < `BMA_DLY_MIN)
            r = `BMA_DLY_MIN;
        else if (v > `BMA_DLY_MAX)
            r = `BMA_DLY_MAX;
        else
            r = v;
        return r;
    endfunction : fn_clamp

    ////////////////////////////////////////////////////////////////////////
    // state

    bma_pkg::bma_state_e state;
    logic [26:0] tick_cnt;
    logic tick;
    logic [2:0] inh_cnt;
    logic dual;
    logic hot;
    logic [2:0] promote;
    logic [3:0] dly [`BMA_NPARAM];
    logic [3:0] cnt [`BMA_NPARAM];
    logic [15:0] meas_a [8];
    logic [15:0] meas_b [8];
    logic [1:0] miss_a;
    logic [1:0] miss_b;
    logic seen_a;
    logic seen_b;
    logic changed_over;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire logic tick_end = tick_cnt == 27'(TICK_CYCLES - 1);
    wire logic live = state == bma_pkg::BMA_RUN;
    wire bma_pkg::bma_param_t oot_a = {miss_a == `BMA_ID_MISS_LIMIT, mon_a_oot};
    wire bma_pkg::bma_param_t oot_b = {miss_b == `BMA_ID_MISS_LIMIT, mon_b_oot};
    wire bma_pkg::bma_param_t cond =
        fn_combine(policy_or, mon_a_ok, mon_b_ok, oot_a, oot_b);
    wire bma_pkg::bma_param_t sb_cond =
        fn_combine(policy_or, mon_a_ok, mon_b_ok, {1'b0, mon_a_sb_oot}, {1'b0, mon_b_sb_oot});
    // faulty monitor blocks operation under OR, both faulty always
    wire logic mon_block = policy_or ? !(mon_a_ok && mon_b_ok) : !(mon_a_ok || mon_b_ok);
    wire bma_pkg::bma_param_t prim =
        `BMA_PRIMARY_MASK | {promote, 4'h0};
    // standby is checked only when hot; a normal standby counts as clean
    wire logic sb_perfect = !hot || sb_cond == 7'h00;
    wire logic sb_avail = dual && !changed_over;
    bma_pkg::bma_param_t expire;
    logic [2:0] first_idx;

    always_comb
    begin
        expire = 7'h00;
        first_idx = 3'h0;
        for (int i = `BMA_NPARAM - 1; i >= 0; i--)
        begin
            expire[i] = cond[i] && (cnt[i] + 4'h1 >= dly[i]);
            if (expire[i])
                first_idx = 3'(i);
        end
    end

    // a tick that meets a power-on command must not evaluate stale inputs
    wire logic eval = tick && live && !pwr_on;
    wire logic exp_p = eval && (mon_block || (expire & prim) != 7'h00);
    wire logic exp_s = eval && !exp_p && (expire & ~prim) != 7'h00;
    wire logic do_change = (exp_p && sb_avail) || (exp_s && sb_avail && sb_perfect);
    wire logic do_off = exp_p && !sb_avail;
    wire logic use_b = !mon_a_ok;

    ////////////////////////////////////////////////////////////////////////
    // one-second tick and power-on inhibit

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || pwr_on || tick_end)
            tick_cnt <= 27'h0;
        else
            tick_cnt <= tick_cnt + 27'h1;
        tick <= !sys_rst && !pwr_on && tick_end;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || pwr_on)
        begin
            state <= bma_pkg::BMA_INHIBIT;
            inh_cnt <= 3'h0;
        end
        else
        begin
            case (state)
                bma_pkg::BMA_INHIBIT:
                begin
                    if (tick)
                        inh_cnt <= inh_cnt + 3'h1;
                    if (tick && inh_cnt + 3'h1 == `BMA_INHIBIT_TICKS)
                        state <= bma_pkg::BMA_RUN;
                end
                bma_pkg::BMA_RUN:
                begin
                    if (do_off)
                        state <= bma_pkg::BMA_OFF;
                end
                bma_pkg::BMA_OFF:
                    state <= bma_pkg::BMA_OFF;
                default:
                    state <= bma_pkg::BMA_INHIBIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            policy_or <= 1'b0;
            dual <= 1'b0;
            hot <= 1'b0;
            promote <= 3'h0;
        end
        else if (cfg_wr)
        begin
            policy_or <= cfg_or_policy;
            dual <= cfg_dual;
            hot <= cfg_hot;
            promote <= cfg_promote;
        end
        standby_tx_on <= !sys_rst && (cfg_wr ? cfg_hot && cfg_dual : hot && dual);
    end

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < `BMA_NPARAM; i++)
        begin
            if (sys_rst)
                dly[i] <= 4'(`BMA_DLY_DEFAULT >> (4 * i));
            else if (cfg_dly_wr && cfg_dly_idx == 3'(i))
                dly[i] <= fn_clamp(cfg_dly_val);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reaction timers

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < `BMA_NPARAM; i++)
        begin
            if (sys_rst || !live || exp_p || exp_s || !cond[i])
                cnt[i] <= 4'h0;
            else if (tick && cnt[i] != `BMA_DLY_MAX)
                cnt[i] <= cnt[i] + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // identity keying watch

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            miss_a <= 2'h0;
            miss_b <= 2'h0;
            seen_a <= 1'b0;
            seen_b <= 1'b0;
        end
        else
        begin
            if (mon_a_id_cycle)
                miss_a <= fn_miss(miss_a, seen_a || mon_a_id_ok);
            if (mon_b_id_cycle)
                miss_b <= fn_miss(miss_b, seen_b || mon_b_id_ok);
            seen_a <= !mon_a_id_cycle && (seen_a || mon_a_id_ok);
            seen_b <= !mon_b_id_cycle && (seen_b || mon_b_id_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // measurements and operator view

    always_ff @(posedge clk_sys)
    begin
        if (mon_a_meas_wr)
            meas_a[mon_a_meas_idx] <= mon_a_meas_val;
        if (mon_b_meas_wr)
            meas_b[mon_b_meas_idx] <= mon_b_meas_val;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            op_val_a <= 16'h0000;
            op_val_b <= 16'h0000;
        end
        else
        begin
            op_val_a <= meas_a[op_idx];
            op_val_b <= meas_b[op_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transponder switching and alarms

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            tx_enable <= 1'b0;
            active_sel <= 1'b0;
            changed_over <= 1'b0;
            eval_live <= 1'b0;
        end
        else
        begin
            eval_live <= live && !do_off && !pwr_on;
            if (pwr_on)
                tx_enable <= 1'b1;
            else if (do_off)
                tx_enable <= 1'b0;
            if (do_change)
            begin
                active_sel <= !active_sel;
                changed_over <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            alarm_primary <= 1'b0;
            alarm_secondary <= 1'b0;
            cause_param <= 3'h0;
            cause_value <= 16'h0000;
            cause_mon_b <= 1'b0;
        end
        else
        begin
            // new alarm wins over a simultaneous acknowledge
            alarm_primary <= exp_p || (alarm_primary && !alarm_ack);
            alarm_secondary <= exp_s || (alarm_secondary && !alarm_ack);
            if (exp_p || exp_s)
            begin
                cause_param <= first_idx;
                cause_value <= use_b ? meas_b[first_idx] : meas_a[first_idx];
                cause_mon_b <= use_b;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            alarm_visual <= 1'b0;
            alarm_acoustic <= 1'b0;
            alarm_remote <= 1'b0;
        end
        else
        begin
            alarm_visual <= exp_p || exp_s || (alarm_visual && !alarm_ack);
            alarm_acoustic <= exp_p || exp_s || (alarm_acoustic && !alarm_ack);
            alarm_remote <= exp_p || exp_s || (alarm_remote && !alarm_ack);
        end
    end

endmodule : bma_alarm_ctrl

// ==== verification/bma_alarm_ctrl_sva.sv ====
// port assertions for the alarm controller
`timescale 1ns/10ps
module bma_alarm_ctrl_sva #(
    parameter int unsigned TICK_CYCLES = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // stimulus side
    input wire logic pwr_on,
    input wire logic cfg_wr,
    input wire logic cfg_or_policy,
    input wire logic cfg_dual,
    input wire logic cfg_hot,
    input wire logic mon_a_meas_wr,
    input wire logic [2:0] mon_a_meas_idx,
    input wire logic [15:0] mon_a_meas_val,
    input wire logic [2:0] op_idx,
    input wire logic alarm_ack,
    // observed side
    input logic [15:0] op_val_a,
    input logic tx_enable,
    input logic active_sel,
    input logic standby_tx_on,
    input logic policy_or,
    input logic eval_live,
    input logic alarm_primary,
    input logic alarm_secondary,
    input logic alarm_visual,
    input logic alarm_acoustic,
    input logic alarm_remote
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // cycles since power-on, saturating
    int unsigned since_on;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || pwr_on)
            since_on <= 0;
        else if (since_on < 5 * TICK_CYCLES)
            since_on <= since_on + 1;
    end
    sequence s_meas_hit;
        (mon_a_meas_wr && mon_a_meas_idx == op_idx) ##1 ($stable(op_idx) && !mon_a_meas_wr);
    endsequence
    ////////////////////////////////////////////////////////////////
    a_policy_load: assert property (cfg_wr |=> policy_or == $past(cfg_or_policy))
        else $error("policy not loaded");
    a_standby_mode: assert property (cfg_wr |=> standby_tx_on == $past(cfg_hot && cfg_dual))
        else $error("standby mode wrong");
    a_live_delay: assert property ($rose(eval_live) |-> since_on >= 5 * TICK_CYCLES)
        else $error("evaluation started early");
    a_alarm_live: assert property (($rose(alarm_primary) || $rose(alarm_secondary)) |-> $past(eval_live))
        else $error("alarm while inhibited");
    a_primary_stop: assert property ($rose(alarm_primary) |-> !tx_enable || active_sel != $past(active_sel))
        else $error("primary kept transmitting");
    a_tx_off_cause: assert property ($fell(tx_enable) && !$past(sys_rst) |-> alarm_primary)
        else $error("transmitter off without primary");
    a_alarm_outputs: assert property ((alarm_primary || alarm_secondary) |-> alarm_visual && alarm_acoustic && alarm_remote)
        else $error("alarm indication missing");
    a_alarm_latch: assert property ($fell(alarm_primary) |-> $past(alarm_ack) || $past(sys_rst))
        else $error("alarm dropped without ack");
    a_op_show: assert property (s_meas_hit |=> op_val_a == $past(mon_a_meas_val, 2))
        else $error("operator value stale");
endmodule : bma_alarm_ctrl_sva

bind bma_alarm_ctrl bma_alarm_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_bma_alarm_ctrl_sva (.*);

// ==== verification/bma_mon_model.sv ====
// behavioural model of one executive monitor
`timescale 1ns/10ps
module bma_mon_model #(
    parameter int ID_CYCLES = 10
) (
    // clock
    input wire logic clk_sys,
    // scenario commands
    input wire logic healthy,
    input wire logic [5:0] oot_cmd,
    input wire logic id_good,
    input wire logic [5:0] sb_cmd,
    // monitor outputs
    output logic ok,
    output logic [5:0] oot,
    output logic [5:0] sb_oot,
    output logic id_cycle,
    output logic id_ok,
    output logic meas_wr,
    output logic [2:0] meas_idx,
    output logic [15:0] meas_val
);
    int cnt = 0;
    initial {ok, oot, sb_oot, id_cycle, id_ok, meas_wr, meas_idx, meas_val} = '0;
    always @(posedge clk_sys)
    begin
        #1;
        cnt = (cnt + 1) % ID_CYCLES;
        ok = healthy;
        // a faulty monitor reports garbage
        oot = healthy ? oot_cmd : ~oot_cmd;
        sb_oot = healthy ? sb_cmd : ~sb_cmd;
        id_cycle = (cnt == 0);
        id_ok = id_good && (cnt == 5);
        meas_wr = cnt[0];
        meas_idx = 3'(cnt % 7);
        // value not qualified by the strobe keeps moving
        meas_val = meas_wr ? {13'h0000, meas_idx} ^ 16'hA500 : ~meas_val;
    end
endmodule : bma_mon_model

// ==== verification/bma_alarm_ctrl_bench.sv ====
// self-checking bench for the alarm controller
`timescale 1ns/10ps
module bma_alarm_ctrl_bench;
    localparam int unsigned TK = 20;
    logic clk_sys = 1'b0, sys_rst = 1'b1, pwr_on = 1'b0, cfg_wr = 1'b0, alarm_ack = 1'b0;
    logic cfg_or_policy = 1'b0, cfg_dual = 1'b0, cfg_hot = 1'b0, cfg_dly_wr = 1'b0;
    logic [2:0] cfg_promote = 3'h0, cfg_dly_idx = 3'h0, op_idx = 3'h2;
    logic [3:0] cfg_dly_val = 4'h0;
    logic a_ok = 1'b1, b_ok = 1'b1, a_id = 1'b1, b_id = 1'b1;
    logic [5:0] a_oot = 6'h00, b_oot = 6'h00, a_sb = 6'h00, b_sb = 6'h00;
    logic mon_a_ok, mon_a_id_cycle, mon_a_id_ok, mon_a_meas_wr;
    logic mon_b_ok, mon_b_id_cycle, mon_b_id_ok, mon_b_meas_wr;
    logic [5:0] mon_a_oot, mon_a_sb_oot, mon_b_oot, mon_b_sb_oot;
    logic [2:0] mon_a_meas_idx, mon_b_meas_idx, cause_param;
    logic [15:0] mon_a_meas_val, mon_b_meas_val, op_val_a, op_val_b, cause_value;
    logic tx_enable, active_sel, standby_tx_on, policy_or, eval_live, cause_mon_b;
    logic alarm_primary, alarm_secondary, alarm_visual, alarm_acoustic, alarm_remote;
    int fails = 0;
    int tests_run = 0;
    always #4 clk_sys = ~clk_sys;
    bma_alarm_ctrl #(.TICK_CYCLES(TK)) u_bma_alarm_ctrl (.*);
    bma_mon_model u_bma_mon_model_a (.clk_sys, .healthy(a_ok), .oot_cmd(a_oot), .id_good(a_id),
        .sb_cmd(a_sb),
        .ok(mon_a_ok), .oot(mon_a_oot), .sb_oot(mon_a_sb_oot), .id_cycle(mon_a_id_cycle),
        .id_ok(mon_a_id_ok), .meas_wr(mon_a_meas_wr), .meas_idx(mon_a_meas_idx),
        .meas_val(mon_a_meas_val));
    bma_mon_model u_bma_mon_model_b (.clk_sys, .healthy(b_ok), .oot_cmd(b_oot), .id_good(b_id),
        .sb_cmd(b_sb),
        .ok(mon_b_ok), .oot(mon_b_oot), .sb_oot(mon_b_sb_oot), .id_cycle(mon_b_id_cycle),
        .id_ok(mon_b_id_ok), .meas_wr(mon_b_meas_wr), .meas_idx(mon_b_meas_idx),
        .meas_val(mon_b_meas_val));
    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic stop_test;
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %b seen %b", name, exp, got);
            fails++;
        end
    endtask : chk
    task automatic timeout(input string name);
        chk(name, 1'b1, 1'b0);
        stop_test();
    endtask : timeout
    task automatic cfg(input logic orp, input logic dual, input logic hot, input logic [2:0] prom);
        {cfg_or_policy, cfg_dual, cfg_hot, cfg_promote, cfg_wr} = {orp, dual, hot, prom, 1'b1};
        cyc(1);
        cfg_wr = 1'b0;
    endtask : cfg
    task automatic power_up;
        int i;
        {a_ok, b_ok, a_id, b_id, a_oot, b_oot} = 16'hF000;
        {alarm_ack, pwr_on} = 2'b11;
        cyc(1);
        {alarm_ack, pwr_on} = 2'b00;
        for (i = 0; i < 8 * TK && eval_live !== 1'b1; i++)
            cyc(1);
        if (i == 8 * TK)
            timeout("eval_live");
        chk("inhibit", 1'b1, i >= 4 * TK);
        chk("tx_enable", 1'b1, tx_enable);
    endtask : power_up
    task automatic wait_alarm(input int lim);
        int i;
        for (i = 0; i < lim && alarm_primary !== 1'b1 && alarm_secondary !== 1'b1; i++)
            cyc(1);
        if (i == lim)
            timeout("alarm");
    endtask : wait_alarm
    ////////////////////////////////////////////////////////////////
    task automatic sc_reset;
        chk("policy_or", 1'b0, policy_or);
        chk("idle", 1'b0, tx_enable | alarm_primary | alarm_secondary | eval_live);
    endtask : sc_reset
    task automatic sc_and;
        power_up();
        chk("op_val", 1'b1, op_val_a === 16'hA502 && op_val_b === 16'hA502);
        a_oot = 6'h01;
        cyc(6 * TK);
        chk("single monitor", 1'b0, alarm_primary);
        b_oot = 6'h01;
        cyc(4 * TK - 3);
        chk("early delay", 1'b0, alarm_primary);
        wait_alarm(3 * TK);
        chk("alarm_primary", 1'b1, alarm_primary);
        chk("tx_enable", 1'b0, tx_enable);
        chk("cause", 1'b1, cause_param === 3'h0 && alarm_visual === 1'b1);
        chk("cause_value", 1'b1, cause_value === 16'hA500 && cause_mon_b === 1'b0);
        chk("indicators", 1'b1, alarm_acoustic && alarm_remote);
    endtask : sc_and
    task automatic sc_or;
        cfg(1'b1, 1'b0, 1'b0, 3'h0);
        chk("policy_or", 1'b1, policy_or);
        power_up();
        b_oot = 6'h08;
        cyc(2 * TK);
        b_oot = 6'h00;
        cyc(TK + 2);
        b_oot = 6'h08;
        cyc(3 * TK - 2);
        chk("restart", 1'b0, alarm_primary);
        wait_alarm(3 * TK);
        chk("or alarm", 1'b1, alarm_primary && cause_param === 3'h3);
        power_up();
        b_ok = 1'b0;
        wait_alarm(3 * TK);
        chk("faulty or", 1'b1, alarm_primary);
        cfg(1'b0, 1'b0, 1'b0, 3'h0);
        power_up();
        a_ok = 1'b0;
        cyc(3 * TK);
        chk("faulty and", 1'b0, alarm_primary | alarm_secondary);
        b_oot = 6'h01;
        wait_alarm(6 * TK);
        chk("one healthy", 1'b1, alarm_primary && cause_mon_b && cause_value === 16'hA500);
    endtask : sc_or
    task automatic sc_second;
        {cfg_dly_idx, cfg_dly_val, cfg_dly_wr} = {3'h5, 4'h0, 1'b1};
        cyc(1);
        cfg_dly_wr = 1'b0;
        power_up();
        {a_oot, b_oot} = 12'h820;
        wait_alarm(3 * TK);
        chk("secondary", 1'b1, alarm_secondary && !alarm_primary);
        chk("tx_enable", 1'b1, tx_enable);
        cfg(1'b0, 1'b0, 1'b0, 3'h2);
        power_up();
        {a_oot, b_oot} = 12'h820;
        wait_alarm(3 * TK);
        chk("promoted", 1'b0, tx_enable | !alarm_primary);
    endtask : sc_second
    task automatic sc_ident;
        power_up();
        {a_id, b_id} = 2'b00;
        cyc(10);
        chk("one miss", 1'b0, alarm_secondary);
        wait_alarm(4 * TK);
        chk("ident", 1'b1, alarm_secondary && cause_param === 3'h6);
    endtask : sc_ident
    task automatic sc_dual;
        logic sel;
        cfg(1'b0, 1'b1, 1'b1, 3'h0);
        chk("standby_tx_on", 1'b1, standby_tx_on);
        power_up();
        sel = active_sel;
        {a_sb, b_sb} = 12'h820;
        {a_oot, b_oot} = 12'h820;
        wait_alarm(3 * TK);
        chk("standby busy", 1'b1, alarm_secondary && active_sel === sel);
        {a_sb, b_sb, alarm_ack} = 13'h0001;
        cyc(1);
        alarm_ack = 1'b0;
        wait_alarm(3 * TK);
        chk("changeover", 1'b1, active_sel === ~sel && tx_enable === 1'b1);
        {a_oot, b_oot, alarm_ack} = 13'h0105;
        cyc(1);
        alarm_ack = 1'b0;
        wait_alarm(6 * TK);
        chk("spacing", 1'b0, tx_enable | !alarm_primary);
    endtask : sc_dual
    ////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(5);
        sys_rst = 1'b0;
        sc_reset();
        sc_and();
        sc_or();
        sc_second();
        sc_ident();
        sc_dual();
        stop_test();
    end
endmodule : bma_alarm_ctrl_bench
